// *** rtl/brscr_pkg.sv ***
// constants shared by the buck sleep configuration register slice
package brscr_pkg;
    // register byte addresses on the control port
    localparam logic [7:0] ADDR_SLEEP_VOLT = 8'h45;
    localparam logic [7:0] ADDR_MODE = 8'h46;
    localparam logic [7:0] ADDR_CONFIG = 8'h47;
    // reset values
    localparam logic [7:0] RST_SLEEP_VOLT = 8'h00;
    localparam logic [3:0] RST_MODE_FIELD = 4'h0;
    localparam logic RST_SLEEP_STATE = 1'b0;
    localparam logic [7:0] RST_CONFIG = 8'h00;
    localparam logic [7:0] RDATA_IDLE = 8'h00;
    // sleep voltage register fields
    localparam int VCODE_LSB = 0;
    localparam int VCODE_W = 6;
    localparam int VRANGE_BIT = 6;
    // mode register fields
    localparam int MODE_LSB = 0;
    localparam int MODE_W = 4;
    localparam int SLEEP_STATE_BIT = 5;
    // configuration register fields
    localparam int ILIM_BIT = 0;
    localparam int FREQ_LSB = 2;
    localparam int PHASE_LSB = 4;
    localparam int RAMP_LSB = 6;
    localparam int SEL_W = 2;
    // switching frequency codes
    localparam logic [1:0] FREQ_CODE_1M = 2'h0;
    localparam logic [1:0] FREQ_CODE_2M = 2'h1;
    localparam logic [1:0] FREQ_CODE_4M = 2'h2;
    // timing, in hertz, and the derived clock dividers
    localparam int SYS_CLK_HZ = 40_000_000;
    localparam int FREQ_1M_HZ = 1_000_000;
    localparam int FREQ_2M_HZ = 2_000_000;
    localparam int FREQ_4M_HZ = 4_000_000;
    localparam int DIV_W = 6;
    localparam logic [DIV_W-1:0] DIV_1M = DIV_W'(SYS_CLK_HZ / FREQ_1M_HZ);
    localparam logic [DIV_W-1:0] DIV_2M = DIV_W'(SYS_CLK_HZ / FREQ_2M_HZ);
    localparam logic [DIV_W-1:0] DIV_4M = DIV_W'(SYS_CLK_HZ / FREQ_4M_HZ);
endpackage : brscr_pkg

// *** rtl/brscr_clk_if.sv ***
// carrier between the register slice and its switching clock generator
`timescale 1ns/100ps
interface brscr_clk_if;
    logic [1:0] freq_sel;
    logic [1:0] phase_sel;
    logic tick;
    modport gen (input freq_sel, input phase_sel, output tick);
    modport ctrl (output freq_sel, output phase_sel, input tick);
endinterface : brscr_clk_if

// *** rtl/brscr_swclk_gen.sv ***
// switching clock tick generator with frequency and phase selection
`timescale 1ns/100ps
module brscr_swclk_gen
    import brscr_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // selection in, tick out
    brscr_clk_if.gen clk_if
);

    logic [DIV_W-1:0] div_sel;
    logic [DIV_W-1:0] offset;
    logic [DIV_W-1:0] cnt_reg;
    logic tick_reg;

    ////////////////////////////////////////////////////////////////////////////
    // unused code 11 falls back to the slowest rate
    always_comb begin
        unique case (clk_if.freq_sel)
            FREQ_CODE_1M: div_sel = DIV_1M;
            FREQ_CODE_2M: div_sel = DIV_2M;
            FREQ_CODE_4M: div_sel = DIV_4M;
            default: div_sel = DIV_1M;
        endcase
    end

    // quarter-period offsets; 4 MHz quarters round down
    always_comb begin
        unique case (clk_if.phase_sel)
            2'h0: offset = '0;
            2'h1: offset = div_sel >> 2;
            2'h2: offset = div_sel >> 1;
            2'h3: offset = (div_sel >> 1) + (div_sel >> 2);
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // >= keeps a rate change mid-period from running past the new end
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            cnt_reg <= '0;
        end else if (cnt_reg >= div_sel - DIV_W'(1)) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_reg + DIV_W'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            tick_reg <= 1'b0;
        end else begin
            tick_reg <= (cnt_reg == offset);
        end
    end

    assign clk_if.tick = tick_reg;

endmodule : brscr_swclk_gen

// *** rtl/brscr_top.sv ***
// sleep voltage, mode and configuration registers of one buck channel
//
// What this block does
// - in sleep, drive the six-bit sleep voltage code; read/write, resets zero
// - sleep range bit is read-only, copied from the normal-mode range bit
// - four-bit mode field selects the switching operation mode
// - sleep state bit: 0 turns regulator off, 1 runs pulse-frequency; resets 0
// - config bit 0: 0 high current limit, 1 low current limit
// - config bits 3:2 select switching frequency, reset 00
// - config bits 5:4 select phase of the internal switching clock
// - config bits 7:6 set the voltage ramp step speed
// - frequency codes 00, 01, 10 give 1, 2 and 4 MHz
`timescale 1ns/100ps
module brscr_top
    import brscr_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // register access from the control port
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_ack_o,
    // device state and normal-mode settings
    input wire logic sleep_i,
    input wire logic [5:0] normal_voltage_code_i,
    input wire logic normal_range_i,
    // regulator controls
    output logic [5:0] vout_code_o,
    output logic vout_range_o,
    output logic [3:0] switching_mode_field_o,
    output logic regulator_on_o,
    output logic pulse_frequency_operation_o,
    output logic current_limit_select_o,
    output logic [1:0] switch_freq_select_o,
    output logic [1:0] phase_clock_select_o,
    output logic [1:0] ramp_speed_select_o,
    output logic sw_tick_o
);

    logic [5:0] sleep_voltage_code_reg;
    logic sleep_range_reg;
    logic [3:0] switching_mode_field_reg;
    logic sleep_state_select_reg;
    logic [7:0] channel_config_byte_reg;
    logic [7:0] rdata_next;
    logic [7:0] rdata_reg;
    logic ack_reg;
    logic [5:0] vout_code_reg;
    logic vout_range_reg;
    logic [3:0] mode_out_reg;
    logic on_reg;
    logic pfm_reg;
    logic wr_volt;
    logic wr_mode;
    logic wr_conf;

    brscr_clk_if clk_if ();

    ////////////////////////////////////////////////////////////////////////////
    // register writes
    assign wr_volt = reg_wr_i && (reg_addr_i == ADDR_SLEEP_VOLT);
    assign wr_mode = reg_wr_i && (reg_addr_i == ADDR_MODE);
    assign wr_conf = reg_wr_i && (reg_addr_i == ADDR_CONFIG);

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            sleep_voltage_code_reg <= RST_SLEEP_VOLT[VCODE_LSB +: VCODE_W];
        end else if (wr_volt) begin
            sleep_voltage_code_reg <= reg_wdata_i[VCODE_LSB +: VCODE_W];
        end
    end

    // range bit ignores writes; it follows the one-time configured normal bit
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            sleep_range_reg <= RST_SLEEP_VOLT[VRANGE_BIT];
        end else begin
            sleep_range_reg <= normal_range_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            switching_mode_field_reg <= RST_MODE_FIELD;
        end else if (wr_mode) begin
            switching_mode_field_reg <= reg_wdata_i[MODE_LSB +: MODE_W];
        end
    end

    // bits 4 and 7:6 have no storage, so writes to them are lost
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            sleep_state_select_reg <= RST_SLEEP_STATE;
        end else if (wr_mode) begin
            sleep_state_select_reg <= reg_wdata_i[SLEEP_STATE_BIT];
        end
    end

    // bit 1 is spare but still stores and reads back
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            channel_config_byte_reg <= RST_CONFIG;
        end else if (wr_conf) begin
            channel_config_byte_reg <= reg_wdata_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register reads; unmapped addresses read zero
    always_comb begin
        rdata_next = RDATA_IDLE;
        unique case (reg_addr_i)
            ADDR_SLEEP_VOLT: begin
                rdata_next[VCODE_LSB +: VCODE_W] = sleep_voltage_code_reg;
                rdata_next[VRANGE_BIT] = sleep_range_reg;
            end
            ADDR_MODE: begin
                rdata_next[MODE_LSB +: MODE_W] = switching_mode_field_reg;
                rdata_next[SLEEP_STATE_BIT] = sleep_state_select_reg;
            end
            ADDR_CONFIG: begin
                rdata_next = channel_config_byte_reg;
            end
            default: begin
                rdata_next = RDATA_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rdata_reg <= RDATA_IDLE;
        end else if (reg_rd_i) begin
            rdata_reg <= rdata_next;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= reg_rd_i || reg_wr_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // regulator control outputs, registered to keep glitches off the analog side
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            vout_code_reg <= '0;
        end else if (sleep_i) begin
            vout_code_reg <= sleep_voltage_code_reg;
        end else begin
            vout_code_reg <= normal_voltage_code_i;
        end
    end

    // range follows the same sleep switch as the code, so both move together
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            vout_range_reg <= 1'b0;
        end else if (sleep_i) begin
            vout_range_reg <= sleep_range_reg;
        end else begin
            vout_range_reg <= normal_range_i;
        end
    end

    // mode copy lags the register by one cycle, like the voltage, on and pulse-frequency controls
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            mode_out_reg <= RST_MODE_FIELD;
        end else begin
            mode_out_reg <= switching_mode_field_reg;
        end
    end

    // normal operation always holds the regulator on; the sleep state bit decides on/off only in sleep
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            on_reg <= 1'b0;
        end else begin
            on_reg <= !sleep_i || sleep_state_select_reg;
        end
    end

    // pulse-frequency running only ever applies while asleep
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            pfm_reg <= 1'b0;
        end else begin
            pfm_reg <= sleep_i && sleep_state_select_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // switching clock generator
    assign clk_if.freq_sel = channel_config_byte_reg[FREQ_LSB +: SEL_W];
    assign clk_if.phase_sel = channel_config_byte_reg[PHASE_LSB +: SEL_W];

    brscr_swclk_gen u_swclk (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .clk_if(clk_if.gen)
    );

    assign reg_rdata_o = rdata_reg;
    assign reg_ack_o = ack_reg;
    assign vout_code_o = vout_code_reg;
    assign vout_range_o = vout_range_reg;
    assign switching_mode_field_o = mode_out_reg;
    assign regulator_on_o = on_reg;
    assign pulse_frequency_operation_o = pfm_reg;
    assign current_limit_select_o = channel_config_byte_reg[ILIM_BIT];
    assign switch_freq_select_o = channel_config_byte_reg[FREQ_LSB +: SEL_W];
    assign phase_clock_select_o = channel_config_byte_reg[PHASE_LSB +: SEL_W];
    assign ramp_speed_select_o = channel_config_byte_reg[RAMP_LSB +: SEL_W];
    assign sw_tick_o = clk_if.tick;

endmodule : brscr_top

// *** test/brscr_top_asserts.sv ***
// port assertions for the buck sleep configuration register slice
`timescale 1ns/100ps
module brscr_top_asserts
    import brscr_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    // device state
    input wire logic sleep_i,
    input wire logic [5:0] normal_voltage_code_i,
    input wire logic normal_range_i,
    // regulator controls
    input wire logic [5:0] vout_code_o,
    input wire logic vout_range_o,
    input wire logic [3:0] switching_mode_field_o,
    input wire logic regulator_on_o,
    input wire logic pulse_frequency_operation_o,
    input wire logic current_limit_select_o,
    input wire logic [1:0] switch_freq_select_o,
    input wire logic [1:0] phase_clock_select_o,
    input wire logic [1:0] ramp_speed_select_o
);
    // the edge that releases reset still shows reset-time outputs, so it is skipped too
    logic rst_dly_reg;
    always_ff @(posedge clk_i) begin
        rst_dly_reg <= sys_rst_i;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i || rst_dly_reg);
    sequence s_wr(logic [7:0] a);
        reg_wr_i && reg_addr_i == a;
    endsequence
    // sleeping writes need two sleep cycles: register first, then output
    sequence s_sleep_wr(logic [7:0] a);
        s_wr(a) ##0 sleep_i ##1 sleep_i;
    endsequence
    property p_cfg_wr;
        s_wr(ADDR_CONFIG) |=> current_limit_select_o == $past(reg_wdata_i[0]) &&
            {ramp_speed_select_o, phase_clock_select_o, switch_freq_select_o} == $past(reg_wdata_i[7:2]);
    endproperty
    a_cfg_wr: assert property (p_cfg_wr) else $error("config outputs differ from write");
    property p_cfg_hold;
        !(reg_wr_i && reg_addr_i == ADDR_CONFIG) |=>
            $stable({ramp_speed_select_o, phase_clock_select_o, switch_freq_select_o, current_limit_select_o});
    endproperty
    a_cfg_hold: assert property (p_cfg_hold) else $error("config outputs moved without write");
    property p_sleep_vcode;
        s_sleep_wr(ADDR_SLEEP_VOLT) |=> vout_code_o == $past(reg_wdata_i[5:0], 2);
    endproperty
    a_sleep_vcode: assert property (p_sleep_vcode) else $error("sleep code not applied");
    property p_awake;
        !sleep_i |=> vout_code_o == $past(normal_voltage_code_i) && regulator_on_o && !pulse_frequency_operation_o;
    endproperty
    a_awake: assert property (p_awake) else $error("awake outputs wrong");
    // the inherited range is given two stable sleep cycles to settle after normal_range_i changes
    property p_range;
        (sleep_i && $stable(normal_range_i)) [*2] |=> vout_range_o == $past(normal_range_i);
    endproperty
    a_range: assert property (p_range) else $error("sleep range not inherited");
    property p_sleep_state;
        s_sleep_wr(ADDR_MODE) |=> pulse_frequency_operation_o == $past(reg_wdata_i[5], 2) &&
            regulator_on_o == $past(reg_wdata_i[5], 2);
    endproperty
    a_sleep_state: assert property (p_sleep_state) else $error("sleep state wrong");
    property p_mode;
        s_wr(ADDR_MODE) |=> ##1 switching_mode_field_o == $past(reg_wdata_i[3:0], 2);
    endproperty
    a_mode: assert property (p_mode) else $error("mode field not applied");
    property p_unused;
        reg_rd_i && reg_addr_i == ADDR_MODE |=> (reg_rdata_o & 8'hd0) == 8'h00;
    endproperty
    a_unused: assert property (p_unused) else $error("unused mode bits read nonzero");
endmodule : brscr_top_asserts
bind brscr_top brscr_top_asserts brscr_top_asserts_i (.*);

// *** test/tb.sv ***
// self-checking bench for the buck sleep configuration register slice
`timescale 1ns/100ps
module tb;
    import brscr_pkg::*;
    logic clk_i = 1'b0, sys_rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0, sleep_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o;
    logic [5:0] normal_voltage_code_i = 6'h15, vout_code_o;
    logic normal_range_i = 1'b1, reg_ack_o, vout_range_o, regulator_on_o, pulse_frequency_operation_o;
    logic current_limit_select_o, sw_tick_o;
    logic [3:0] switching_mode_field_o;
    logic [1:0] switch_freq_select_o, phase_clock_select_o, ramp_speed_select_o;
    logic [15:0] seed = 16'h5eee;
    logic [7:0] shadow [3] = '{8'h00, 8'h00, 8'h00};
    int miscompares = 0, check_count = 0, cyc = 0;
    int per [4] = '{40, 20, 10, 40};
    brscr_top brscr_top_i (.*);
    always #12.5 clk_i = ~clk_i;
    // generous ceiling: the whole sequence needs well under 2000 cycles
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            miscompares++;
            results();
        end
    end
    function logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    function logic [7:0] rd_exp(input logic [7:0] a);
        case (a)
            ADDR_SLEEP_VOLT: return {1'b0, normal_range_i, shadow[0][5:0]};
            ADDR_MODE: return shadow[1] & 8'h2f;
            ADDR_CONFIG: return shadow[2];
            default: return 8'h00;
        endcase
    endfunction : rd_exp
    task chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
        if (a inside {[ADDR_SLEEP_VOLT:ADDR_CONFIG]}) shadow[a - ADDR_SLEEP_VOLT] = d;
        #1 chk({7'h00, reg_ack_o}, 8'h01);
    endtask : wr
    task rd(input logic [7:0] a);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1 chk(reg_rdata_o, rd_exp(a));
    endtask : rd
    task period(input logic [1:0] f, input int exp);
        int n;
        wr(ADDR_CONFIG, {4'h0, f, 2'h0});
        // the first interval after a change may be short, so the third is measured
        repeat (3) begin
            n = 0;
            do begin
                @(negedge clk_i);
                n++;
            end while (sw_tick_o !== 1'b1 && n < 100);
        end
        chk(8'(n), 8'(exp));
    endtask : period
    // each step moves the tick a quarter period later than the previous phase
    task phase(input logic [1:0] p);
        int n;
        n = 0;
        fork
            wr(ADDR_CONFIG, {2'h0, p, FREQ_CODE_1M, 2'h0});
            do begin
                @(negedge clk_i);
                n++;
            end while (sw_tick_o !== 1'b1 && n < 100);
        join
        chk(8'(n), 8'(per[0] / 4));
    endtask : phase
    task results();
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : results
    initial begin
        repeat (3) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        for (logic [7:0] a = 8'h45; a < 8'h49; a++) rd(a);
        wr(ADDR_SLEEP_VOLT, 8'hff);
        rd(ADDR_SLEEP_VOLT);
        @(posedge clk_i) normal_range_i <= 1'b0;
        rd(ADDR_SLEEP_VOLT);
        for (int m = 0; m < 16; m++) begin
            seed = lfsr(seed);
            wr(ADDR_MODE, {seed[7:4], 4'(m)});
            rd(ADDR_MODE);
            chk({4'h0, switching_mode_field_o}, {4'h0, 4'(m)});
        end
        repeat (24) begin
            seed = lfsr(seed);
            wr(ADDR_SLEEP_VOLT + 8'(seed[1:0]), seed[15:8]);
            rd(ADDR_SLEEP_VOLT + 8'(seed[1:0]));
            chk({ramp_speed_select_o, phase_clock_select_o, switch_freq_select_o, 1'b0, current_limit_select_o},
                shadow[2] & 8'hfd);
        end
        @(posedge clk_i) sleep_i <= 1'b1;
        wr(ADDR_SLEEP_VOLT, 8'h2a);
        wr(ADDR_MODE, 8'h20);
        repeat (3) @(negedge clk_i);
        chk({vout_code_o, regulator_on_o, pulse_frequency_operation_o}, {6'h2a, 2'b11});
        wr(ADDR_MODE, 8'h00);
        repeat (3) @(negedge clk_i);
        chk({vout_code_o, regulator_on_o, pulse_frequency_operation_o}, {6'h2a, 2'b00});
        @(posedge clk_i) sleep_i <= 1'b0;
        repeat (3) @(negedge clk_i);
        chk({vout_code_o, regulator_on_o, pulse_frequency_operation_o}, {6'h15, 2'b10});
        for (int f = 0; f < 4; f++) period(2'(f), per[f]);
        for (int p = 1; p < 5; p++) phase(2'(p));
        results();
    end
endmodule : tb
